// ---- logic/ric_pkg.sv ----
// Purpose: Shared constants for the reader status and interrupt block
// Assumes: Byte-wide host register port, registers at their printed offsets
// Notes: Bit positions are the positions inside each 8-bit register
package ric_pkg;
   localparam logic [7:0] ADDR_PROTOCOL_CTRL = 8'h01;
   localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h0c;
   localparam logic [7:0] ADDR_CLASH_HI_MASK = 8'h0d;
   localparam logic [7:0] ADDR_CLASH_LO = 8'h0e;
   localparam logic [7:0] ADDR_STRENGTH = 8'h0f;

   localparam logic [7:0] RST_IRQ_CAUSE = 8'h00;
   localparam logic [7:0] RST_CLASH_HI_MASK = 8'h3e;
   localparam logic [7:0] RST_CLASH_LO = 8'h00;

   // Cause register bits
   localparam int BIT_TX = 7;
   localparam int BIT_RX = 6;
   localparam int BIT_FIFO = 5;
   localparam int BIT_CRC = 4;
   localparam int BIT_PARITY = 3;
   localparam int BIT_FRAMING = 2;
   localparam int BIT_CLASH = 1;
   localparam int BIT_NORESP = 0;

   // Mask register layout: position bits 9:8 on top, enables below
   localparam int MASK_POS_LSB = 6;
   localparam int MASK_EN_MSB = 5;

   // Strength register layout
   localparam int STR_OSC_BIT = 6;
   localparam int STR_AUX_LSB = 3;
   localparam int STR_ACT_LSB = 0;

   // FIFO level thresholds in bytes
   localparam int FIFO_LOW_DEF = 4;
   localparam int FIFO_HIGH_DEF = 8;
endpackage

// ---- logic/ric_strength_if.sv ----
// Purpose: Carries channel strength readings between the status core and its capture unit
// Assumes: Single clock domain
// Notes: Readings are 3-bit codes, 4 dB per step
`timescale 1ns/10ps
interface ric_strength_if;
   logic [2:0] am_level;
   logic [2:0] pm_level;
   logic swap_channels;
   logic osc_stable;
   logic rx_start;
   logic tx_start;
   logic [7:0] strength_byte;

   modport core (output am_level, pm_level, swap_channels, osc_stable, rx_start, tx_start,
                 input strength_byte);
   modport capture (input am_level, pm_level, swap_channels, osc_stable, rx_start, tx_start,
                    output strength_byte);
endinterface

// ---- logic/ric_strength.sv ----
// Purpose: Holds the channel strength readings and oscillator flag
// Assumes: rx_start and tx_start are one-cycle pulses
// Notes: Readings track the channels from reception start until next transmission start
`timescale 1ns/10ps
module ric_strength (
   input wire logic mclk,
   input wire logic reset,
   ric_strength_if.capture sif
);
   logic tracking;
   logic [2:0] active_level;
   logic [2:0] aux_level;

   // Active defaults to amplitude, auxiliary to phase; swap reverses them
   always_comb begin
      active_level = sif.swap_channels ? sif.pm_level : sif.am_level;
      aux_level = sif.swap_channels ? sif.am_level : sif.pm_level;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tracking <= 1'b0;
      end else if (sif.tx_start) begin
         tracking <= 1'b0;
      end else if (sif.rx_start) begin
         tracking <= 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sif.strength_byte <= 8'h00;
      end else begin
         sif.strength_byte[7] <= 1'b0;
         sif.strength_byte[ric_pkg::STR_OSC_BIT] <= sif.osc_stable;
         if (sif.rx_start || (tracking && !sif.tx_start)) begin
            sif.strength_byte[ric_pkg::STR_AUX_LSB +: 3] <= aux_level;
            sif.strength_byte[ric_pkg::STR_ACT_LSB +: 3] <= active_level;
         end
      end
   end

   hold_after_tx_a: assert property (@(posedge mclk) disable iff (reset)
      (!tracking && !sif.rx_start) |=> $stable(sif.strength_byte[5:0]))
      else $error("Strength reading changed outside reception");
endmodule

// ---- logic/ric_status.sv ----
// Purpose: Interrupt cause, mask, error position and strength registers of the reader
// Assumes: Host port signals synchronous to mclk; reg_rd and reg_wr are one-cycle strobes
// Notes: Read data appears one cycle after reg_rd; read-clear acts on that same edge
`timescale 1ns/10ps

// Notes on behaviour
// - Cause register clears on reset, disable, protocol write
// - Reading cause register clears it and drops request
// - Transmit flag at start, request at end
// - Receive flag at start-of-frame, request at end
// - FIFO flag when below 4 or above 8 during a transfer
// - CRC, parity, framing errors flagged in separate bits
// - Collision flag only for collision-capable protocols
// - No-response flag tells host to send next slot
// - Mask register resets to 0x3E
// - Mask bits five to zero enable cause bits five to zero
// - Ten-bit position split across two registers
// - Position bits clear after host reads them
// - Without collision detection, position records error bit
// - Lower position register resets to zero
// - Strength readings valid from reception to next transmission
// - Auxiliary strength in bits five to three
// - Active strength in bits two to zero
// - Bit six shows oscillator stable
// - Channel swap control exchanges amplitude and phase
// - FIFO reset command clears lower position register
module ric_status #(
   parameter int FIFO_LOW = ric_pkg::FIFO_LOW_DEF,
   parameter int FIFO_HIGH = ric_pkg::FIFO_HIGH_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic chip_enable,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic fifo_reset_cmd,
   input wire logic tx_start,
   input wire logic tx_end,
   input wire logic rx_sof,
   input wire logic rx_end,
   input wire logic [3:0] fifo_count,
   input wire logic crc_error,
   input wire logic parity_error,
   input wire logic framing_error,
   input wire logic clash_detect,
   input wire logic clash_capable,
   input wire logic [9:0] event_bit_pos,
   input wire logic no_response,
   input wire logic [2:0] am_level,
   input wire logic [2:0] pm_level,
   input wire logic swap_channels,
   input wire logic osc_stable,
   output logic irq
);
   if (FIFO_LOW < 1 || FIFO_HIGH <= FIFO_LOW || FIFO_HIGH > 14) begin : g_fifo_check
      $error("FIFO thresholds out of range");
   end

   localparam logic [3:0] LOW_LVL = 4'(FIFO_LOW);
   localparam logic [3:0] HIGH_LVL = 4'(FIFO_HIGH);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic strobe);
      hit = strobe && (a == target);
   endfunction

   logic [7:0] cause;
   logic [7:0] clash_hi_mask;
   logic [7:0] clash_lo;
   logic tx_busy;
   logic rx_busy;
   logic tx_done;
   logic rx_done;
   logic soft_clear;
   logic read_cause;
   logic read_hi;
   logic read_lo;
   logic fifo_odd;
   logic pos_event;
   logic clash_evt;
   logic [7:0] next_events;
   logic proto_write;

   ric_strength_if sif ();

   ////////////////////////////////////////////////////////////////////////////
   // Host access decode

   assign soft_clear = !chip_enable;
   assign proto_write = hit(reg_addr, ric_pkg::ADDR_PROTOCOL_CTRL, reg_wr);
   assign read_cause = hit(reg_addr, ric_pkg::ADDR_IRQ_CAUSE, reg_rd);
   assign read_hi = hit(reg_addr, ric_pkg::ADDR_CLASH_HI_MASK, reg_rd);
   assign read_lo = hit(reg_addr, ric_pkg::ADDR_CLASH_LO, reg_rd);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ric_pkg::ADDR_IRQ_CAUSE: reg_rdata <= cause;
            ric_pkg::ADDR_CLASH_HI_MASK: reg_rdata <= clash_hi_mask;
            ric_pkg::ADDR_CLASH_LO: reg_rdata <= clash_lo;
            ric_pkg::ADDR_STRENGTH: reg_rdata <= sif.strength_byte;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer progress

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_busy <= 1'b0;
         rx_busy <= 1'b0;
      end else if (soft_clear) begin
         tx_busy <= 1'b0;
         rx_busy <= 1'b0;
      end else begin
         if (tx_start) begin
            tx_busy <= 1'b1;
         end else if (tx_end) begin
            tx_busy <= 1'b0;
         end
         if (rx_sof) begin
            rx_busy <= 1'b1;
         end else if (rx_end) begin
            rx_busy <= 1'b0;
         end
      end
   end

   // Completion latches hold the request side of the transfer flags
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_done <= 1'b0;
         rx_done <= 1'b0;
      end else if (soft_clear || proto_write) begin
         tx_done <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         tx_done <= tx_end || (tx_done && !read_cause);
         rx_done <= rx_end || (rx_done && !read_cause);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cause register

   assign fifo_odd = (fifo_count < LOW_LVL) || (fifo_count > HIGH_LVL);
   assign clash_evt = clash_detect && clash_capable;

   always_comb begin
      next_events = 8'h00;
      next_events[ric_pkg::BIT_TX] = tx_start || tx_end;
      next_events[ric_pkg::BIT_RX] = rx_sof || rx_end;
      next_events[ric_pkg::BIT_FIFO] = fifo_odd && (tx_busy || rx_busy);
      next_events[ric_pkg::BIT_CRC] = crc_error;
      next_events[ric_pkg::BIT_PARITY] = parity_error;
      next_events[ric_pkg::BIT_FRAMING] = framing_error;
      next_events[ric_pkg::BIT_CLASH] = clash_evt;
      next_events[ric_pkg::BIT_NORESP] = no_response;
   end

   // A new event on the read-clear edge survives the clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cause <= ric_pkg::RST_IRQ_CAUSE;
      end else if (soft_clear || proto_write) begin
         cause <= ric_pkg::RST_IRQ_CAUSE;
      end else if (read_cause) begin
         cause <= next_events;
      end else begin
         cause <= cause | next_events;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mask and error position

   // Collision position for capable protocols, error position otherwise
   assign pos_event = clash_capable ? clash_detect
                                    : (crc_error || parity_error || framing_error);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clash_hi_mask <= ric_pkg::RST_CLASH_HI_MASK;
      end else if (soft_clear) begin
         clash_hi_mask <= ric_pkg::RST_CLASH_HI_MASK;
      end else begin
         if (hit(reg_addr, ric_pkg::ADDR_CLASH_HI_MASK, reg_wr)) begin
            clash_hi_mask[ric_pkg::MASK_EN_MSB:0] <= reg_wdata[ric_pkg::MASK_EN_MSB:0];
         end
         if (pos_event) begin
            clash_hi_mask[7:ric_pkg::MASK_POS_LSB] <= event_bit_pos[9:8];
         end else if (read_hi) begin
            clash_hi_mask[7:ric_pkg::MASK_POS_LSB] <= 2'b00;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clash_lo <= ric_pkg::RST_CLASH_LO;
      end else if (soft_clear) begin
         clash_lo <= ric_pkg::RST_CLASH_LO;
      end else if (pos_event) begin
         clash_lo <= event_bit_pos[7:0];
      end else if (read_lo || fifo_reset_cmd) begin
         clash_lo <= ric_pkg::RST_CLASH_LO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(cause[ric_pkg::MASK_EN_MSB:0] & clash_hi_mask[ric_pkg::MASK_EN_MSB:0])
                || (tx_done && cause[ric_pkg::BIT_TX])
                || (rx_done && cause[ric_pkg::BIT_RX]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strength readings

   assign sif.am_level = am_level;
   assign sif.pm_level = pm_level;
   assign sif.swap_channels = swap_channels;
   assign sif.osc_stable = osc_stable;
   assign sif.rx_start = rx_sof;
   assign sif.tx_start = tx_start;

   ric_strength u_strength (
      .mclk(mclk),
      .reset(reset),
      .sif(sif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   cause_disable_clear_a: assert property (@(posedge mclk) disable iff (reset)
      !chip_enable |=> (cause == ric_pkg::RST_IRQ_CAUSE))
      else $error("Cause not cleared while disabled");

   cause_proto_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && proto_write) |=> (cause == ric_pkg::RST_IRQ_CAUSE))
      else $error("Cause not cleared by protocol write");

   read_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && read_cause && next_events == 8'h00 && !tx_end && !rx_end)
      |=> (cause == 8'h00) ##1 !irq)
      else $error("Cause read did not clear request");

   tx_request_late_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && tx_start && !tx_end && !tx_done && !rx_done && !rx_end && !reg_wr
       && ((cause[5:0] | next_events[5:0]) & clash_hi_mask[5:0]) == 6'h00) |=> ##1 !irq)
      else $error("Transmit request raised before end");

   tx_start_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && tx_start && !proto_write) |=> cause[ric_pkg::BIT_TX])
      else $error("Transmit flag not set at start");

   tx_done_irq_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && tx_end && !proto_write) |=> ##1 irq)
      else $error("Transmit end did not raise request");

   rx_sof_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && rx_sof && !proto_write) |=> cause[ric_pkg::BIT_RX])
      else $error("Receive flag not set at start");

   rx_done_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (rx_end && chip_enable && !proto_write)
      |=> (cause[6] && rx_done) ##1 irq)
      else $error("Receive end did not raise request");

   fifo_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && (tx_busy || rx_busy) && fifo_count == 4'h3 && !proto_write) |=> cause[5])
      else $error("FIFO level flag missing");

   crc_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && crc_error && !proto_write) |=> cause[ric_pkg::BIT_CRC])
      else $error("CRC error flag missing");

   parity_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && parity_error && !proto_write) |=> cause[ric_pkg::BIT_PARITY])
      else $error("Parity error flag missing");

   framing_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && framing_error && !proto_write) |=> cause[ric_pkg::BIT_FRAMING])
      else $error("Framing error flag missing");

   clash_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && clash_detect && clash_capable && !proto_write) |=> cause[ric_pkg::BIT_CLASH])
      else $error("Collision flag missing");

   clash_gate_a: assert property (@(posedge mclk) disable iff (reset)
      (!clash_capable && clash_detect && !cause[1]) |=> !cause[1])
      else $error("Collision flag from incapable protocol");

   noresp_flag_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && no_response && !proto_write) |=> cause[ric_pkg::BIT_NORESP])
      else $error("No-response flag missing");

   mask_reset_a: assert property (@(posedge mclk) disable iff (reset)
      !chip_enable |=> (clash_hi_mask == ric_pkg::RST_CLASH_HI_MASK))
      else $error("Mask register not reset while disabled");

   mask_write_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && hit(reg_addr, ric_pkg::ADDR_CLASH_HI_MASK, reg_wr)) |=> (clash_hi_mask[5:0] == $past(reg_wdata[5:0])))
      else $error("Mask enables not written");

   mask_enable_a: assert property (@(posedge mclk) disable iff (reset)
      (cause[0] && clash_hi_mask[0]) |=> irq)
      else $error("Enabled cause did not raise request");

   mask_block_a: assert property (@(posedge mclk) disable iff (reset)
      (cause[5:0] & clash_hi_mask[5:0]) == 6'h00 && !tx_done && !rx_done |=> !irq)
      else $error("Request without enabled cause");

   hi_read_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && read_hi && !pos_event) |=> (clash_hi_mask[7:6] == 2'b00))
      else $error("Upper position not cleared by read");

   pos_low_reset_a: assert property (@(posedge mclk) disable iff (reset)
      !chip_enable |=> (clash_lo == ric_pkg::RST_CLASH_LO))
      else $error("Lower position not reset while disabled");

   pos_low_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && !pos_event && (read_lo || fifo_reset_cmd)) |=> (clash_lo == 8'h00))
      else $error("Lower position not cleared");

   pos_capture_a: assert property (@(posedge mclk) disable iff (reset)
      (chip_enable && pos_event) |=> ({clash_hi_mask[7:6], clash_lo} == $past(event_bit_pos)))
      else $error("Position not captured");

   strength_read_a: assert property (@(posedge mclk) disable iff (reset)
      (reg_rd && reg_addr == ric_pkg::ADDR_STRENGTH) |=> (reg_rdata == $past(sif.strength_byte)))
      else $error("Strength register read mismatch");
endmodule

// ---- tb/ric_host_model.sv ----
// Purpose: Host side of the register port, issuing one-cycle read and write strobes
// Assumes: Strobes are taken on the rising mclk edge, read data stands one cycle later
// Notes: Address lines are inverted once released, and data lines too after a write, so stale values never match
`timescale 1ns/10ps
module ric_host_model (
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// ---- tb/reader_irq_status_collision_tb_top.sv ----
// Purpose: Self-checking bench for the status, mask, position and strength registers
// Assumes: Event inputs are one-cycle pulses driven 1 ns after the rising edge
// Notes: ev packs the event pulses: 0 noresp, 1 clash, 2 framing, 3 parity, 4 crc, 5..8 tx/rx, 9 fifo reset
`timescale 1ns/10ps
module reader_irq_status_collision_tb_top;
   localparam logic [7:0] a_cause = ric_pkg::ADDR_IRQ_CAUSE;
   localparam logic [7:0] a_mask = ric_pkg::ADDR_CLASH_HI_MASK;
   localparam logic [7:0] a_lo = ric_pkg::ADDR_CLASH_LO;
   localparam logic [7:0] a_str = ric_pkg::ADDR_STRENGTH;
   logic mclk, reset, chip_enable, clash_capable, swap_channels, osc_stable, irq, reg_wr, reg_rd;
   logic [9:0] ev, event_bit_pos;
   logic [3:0] fifo_count;
   logic [2:0] am_level, pm_level;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   int fails, n_tests;
   int cycles = 0;

   ric_status i_ric_status (.mclk(mclk), .reset(reset), .chip_enable(chip_enable), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fifo_reset_cmd(ev[9]), .tx_start(ev[5]), .tx_end(ev[6]), .rx_sof(ev[7]), .rx_end(ev[8]),
      .fifo_count(fifo_count), .crc_error(ev[4]), .parity_error(ev[3]), .framing_error(ev[2]),
      .clash_detect(ev[1]), .clash_capable(clash_capable), .event_bit_pos(event_bit_pos),
      .no_response(ev[0]), .am_level(am_level), .pm_level(pm_level), .swap_channels(swap_channels),
      .osc_stable(osc_stable), .irq(irq));
   ric_host_model i_ric_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic pulse(input int i);
      @(posedge mclk);
      #1;
      ev[i] = 1'b1;
      wt(1);
      ev[i] = 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_ric_host_model.rd(a, d);
      chk8(d, e);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rchk(a_cause, 8'h00);
      rchk(a_mask, 8'h3e);
      rchk(a_lo, 8'h00);
      rchk(8'h20, 8'h00);
   endtask

   // Flag appears at start, request only at end, read clears both
   task automatic t_txrx(input int s, input logic [7:0] e);
      pulse(s);
      wt(3);
      chk8({7'h0, irq}, 8'h00);
      pulse(s + 1);
      wt(1);
      chk8({7'h0, irq}, 8'h01);
      rchk(a_cause, e);
      wt(1);
      chk8({7'h0, irq}, 8'h00);
      rchk(a_cause, 8'h00);
   endtask

   task automatic t_errs();
      clash_capable = 1'b1;
      event_bit_pos = 10'h2a5;
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         wt(1);
         chk8({7'h0, irq}, {7'h0, i != 0});
         rchk(a_cause, 8'h01 << i);
      end
      rchk(a_mask, 8'hbe);
      rchk(a_lo, 8'ha5);
      rchk(a_mask, 8'h3e);
      rchk(a_lo, 8'h00);
   endtask

   task automatic t_nocol();
      clash_capable = 1'b0;
      event_bit_pos = 10'h155;
      pulse(1);
      wt(1);
      rchk(a_cause, 8'h00);
      pulse(3);
      rchk(a_mask, 8'h7e);
      rchk(a_lo, 8'h55);
      pulse(4);
      pulse(9);
      rchk(a_lo, 8'h00);
      rchk(a_mask, 8'h7e);
      rchk(a_cause, 8'h18);
   endtask

   task automatic t_mask();
      i_ric_host_model.wr(a_mask, 8'hc0);
      rchk(a_mask, 8'h00);
      pulse(4);
      wt(2);
      chk8({7'h0, irq}, 8'h00);
      rchk(a_cause, 8'h10);
      i_ric_host_model.wr(a_mask, 8'h01);
      pulse(0);
      wt(1);
      chk8({7'h0, irq}, 8'h01);
      i_ric_host_model.wr(ric_pkg::ADDR_PROTOCOL_CTRL, 8'h00);
      rchk(a_cause, 8'h00);
   endtask

   // Counts 3, 4, 8, 9 while receiving: only 3 and 9 flag
   task automatic t_fifo();
      logic [15:0] cnt = 16'h9843;
      pulse(7);
      for (int i = 0; i < 4; i++) begin
         fifo_count = cnt[4 * i +: 4];
         wt(2);
         i_ric_host_model.rd(a_cause, d);
         rchk(a_cause, (i == 0 || i == 3) ? 8'h20 : 8'h00);
      end
      fifo_count = 4'h6;
      pulse(8);
      rchk(a_cause, 8'h60);
   endtask

   task automatic t_str();
      pulse(7);
      wt(1);
      rchk(a_str, 8'h55);
      swap_channels = 1'b1;
      wt(1);
      rchk(a_str, 8'h6a);
      pulse(5);
      am_level = 3'h1;
      wt(2);
      rchk(a_str, 8'h6a);
   endtask

   task automatic t_dis();
      pulse(4);
      i_ric_host_model.wr(a_mask, 8'h00);
      chip_enable = 1'b0;
      wt(2);
      chip_enable = 1'b1;
      wt(1);
      rchk(a_cause, 8'h00);
      rchk(a_mask, 8'h3e);
      rchk(a_lo, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always #20 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      chip_enable = 1'b1;
      ev = 10'h000;
      fifo_count = 4'h6;
      clash_capable = 1'b1;
      event_bit_pos = 10'h2a5;
      am_level = 3'h5;
      pm_level = 3'h2;
      swap_channels = 1'b0;
      osc_stable = 1'b1;
      fails = 0;
      n_tests = 0;
      repeat (16) @(posedge mclk);
      #1;
      reset = 1'b0;
      t_reset();
      t_txrx(5, 8'h80);
      t_txrx(7, 8'h40);
      t_errs();
      t_nocol();
      t_mask();
      t_fifo();
      t_str();
      t_dis();
      summarize();
   end
endmodule
